// *** core/led_ind_pkg.sv ***
// constants, register layout and colour codes for the indicator logic
package led_ind_pkg;

  // register byte offsets
  localparam logic [3:0] CFG_OFS    = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // configuration field positions
  localparam int INV_LSB     = 0;
  localparam int LATCH_BIT   = 8;
  localparam int ACT_LSB     = 16;
  localparam int INACT_LSB   = 20;
  localparam int ACK_SEL_LSB = 24;
  localparam int COLOUR_W    = 3;
  localparam int ACK_SEL_W   = 4;
  localparam int INV_W       = 8;

  // status field positions
  localparam int ST_RAW_LSB  = 0;
  localparam int ST_COMB_BIT = 8;
  localparam int ST_HELD_BIT = 9;
  localparam int ST_ACK_BIT  = 10;
  localparam int ST_RED_BIT  = 16;
  localparam int ST_GRN_BIT  = 17;

  // colour encodings
  typedef enum logic [2:0] {
    COL_GREEN       = 3'h0,
    COL_RED         = 3'h1,
    COL_RED_FLASH   = 3'h2,
    COL_GREEN_FLASH = 3'h3,
    COL_OFF         = 3'h4
  } colour_t;

  // values after reset: active red, inactive off, no latch, ack from input 0
  localparam logic [31:0] CFG_RESET = 32'h0041_0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // blink timing: half period in ms, cycles at 200 MHz
  localparam int CLK_PERIOD_NS  = 5;
  localparam int BLINK_HALF_MS  = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

endpackage : led_ind_pkg

// *** core/led_indicator_logic.sv ***
// one front-panel indicator: input combination, latch, acknowledge, colour and blink
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps

module led_indicator_logic #(
  parameter int NUM_SIG        = 5,
  parameter int BLINK_HALF_CYC = led_ind_pkg::BLINK_HALF_CYC
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [NUM_SIG-1:0] sig_in,
  input  wire logic               ack_ext,
  output logic                    led_red,
  output logic                    led_green,
  output logic                    ack_state,
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  // refuse sizes the logic cannot serve: ack_sel must still reach the external line
  if (NUM_SIG < 1 || NUM_SIG > 5) begin : g_num_sig_chk
    $error("NUM_SIG must be 1..5");
  end
  if (BLINK_HALF_CYC < 2) begin : g_blink_chk
    $error("BLINK_HALF_CYC must be at least 2");
  end

  // colour code plus blink phase to {red, green}; unknown codes stay dark
  function automatic logic [1:0] colour_fn(input logic [2:0] code, input logic phase);
    logic [1:0] rg;
    rg = 2'h0;
    unique case (code)
      led_ind_pkg::COL_GREEN:       rg = 2'h1;
      led_ind_pkg::COL_RED:         rg = 2'h2;
      led_ind_pkg::COL_RED_FLASH:   rg = {phase, 1'b0};
      led_ind_pkg::COL_GREEN_FLASH: rg = {1'b0, phase};
      default:                      rg = 2'h0;
    endcase
    return rg;
  endfunction : colour_fn

  logic [31:0]        cfg_q;
  logic [31:0]        cfg_d;
  logic               held_q;
  logic               held_d;
  logic [NUM_SIG-1:0] cause_q;
  logic [NUM_SIG-1:0] cause_d;
  logic               phase_q;
  logic [31:0]        blink_cnt_q;
  logic               led_red_q;
  logic               led_green_q;
  logic               ack_state_q;

  // configuration fields
  wire [NUM_SIG-1:0] inv_mask  = cfg_q[led_ind_pkg::INV_LSB +: NUM_SIG];
  wire               latch_en  = cfg_q[led_ind_pkg::LATCH_BIT];
  wire [2:0]         act_col   = cfg_q[led_ind_pkg::ACT_LSB +: led_ind_pkg::COLOUR_W];
  wire [2:0]         inact_col = cfg_q[led_ind_pkg::INACT_LSB +: led_ind_pkg::COLOUR_W];
  wire [3:0]         ack_sel   = cfg_q[led_ind_pkg::ACK_SEL_LSB +: led_ind_pkg::ACK_SEL_W];

  // inversion then OR of the assigned inputs
  wire [NUM_SIG-1:0] eff_sig  = sig_in ^ inv_mask;
  wire               combined = |eff_sig;

  // acknowledge taken from an input, the external line, or nothing
  wire ack_raw = (ack_sel < 4'(NUM_SIG)) ? sig_in[ack_sel[2:0]] :
                 (ack_sel == 4'(NUM_SIG)) ? ack_ext : 1'b0;
  // an acknowledge can only clear a latched hold once its causes are all gone
  wire causes_gone = ((eff_sig & cause_q) == '0);
  wire ack_clear   = latch_en & ack_raw & causes_gone & ~combined;

  // latch: pickup wins over an acknowledge in the same cycle
  always_comb begin
    held_d  = held_q;
    cause_d = cause_q;
    if (!latch_en) begin
      held_d  = 1'b0;
      cause_d = '0;
    end else if (combined) begin
      held_d  = 1'b1;
      cause_d = cause_q | eff_sig;
    end else if (ack_clear) begin
      held_d  = 1'b0;
      cause_d = '0;
    end
  end

  wire       indication = combined | held_q;
  wire [1:0] rg_next    = indication ? colour_fn(act_col, phase_q)
                                     : colour_fn(inact_col, phase_q);
  wire       blink_tick = (blink_cnt_q == 32'(BLINK_HALF_CYC - 1));

  // blink divider: equal on and off halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt_q <= 32'h0;
      phase_q     <= 1'b0;
    end else if (blink_tick) begin
      blink_cnt_q <= 32'h0;
      phase_q     <= ~phase_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // latch state and registered pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q      <= 1'b0;
      cause_q     <= '0;
      led_red_q   <= 1'b0;
      led_green_q <= 1'b0;
      ack_state_q <= 1'b0;
    end else begin
      held_q      <= held_d;
      cause_q     <= cause_d;
      led_red_q   <= rg_next[1];
      led_green_q <= rg_next[0];
      ack_state_q <= ack_raw;
    end
  end

  assign led_red   = led_red_q;
  assign led_green = led_green_q;
  assign ack_state = ack_state_q;

  // ---- AXI4-Lite slave ----
  logic        aw_have_q;
  logic [3:0]  aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  // address and data captured independently, write once both are in hand
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  wire   wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
  wire   wr_cfg   = wr_fire & (aw_addr_q[3:2] == led_ind_pkg::CFG_OFS[3:2]);
  wire   wr_stat  = aw_addr_q[3:2] == led_ind_pkg::STATUS_OFS[3:2];
  wire   rd_fire  = s_axi_arvalid & s_axi_arready;
  wire   rd_cfg   = s_axi_araddr[3:2] == led_ind_pkg::CFG_OFS[3:2];
  wire   rd_stat  = s_axi_araddr[3:2] == led_ind_pkg::STATUS_OFS[3:2];

  // byte-lane merge for the configuration word; status is read only
  wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                           {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign cfg_d = wr_cfg ? ((cfg_q & ~strb_mask) | (w_data_q & strb_mask)) : cfg_q;

  // status word showing the live state of the indicator
  wire [31:0] status_word = {14'h0, led_green_q, led_red_q, 5'h0, ack_state_q,
                             held_q, combined, (8'(sig_in))};
  wire [31:0] rd_word     = rd_cfg ? cfg_q : (rd_stat ? status_word : 32'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response and configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q    <= led_ind_pkg::CFG_RESET;
      bvalid_q <= 1'b0;
      bresp_q  <= led_ind_pkg::RESP_OKAY;
    end else begin
      cfg_q <= cfg_d;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_cfg | wr_stat) ? led_ind_pkg::RESP_OKAY : led_ind_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel, unmapped reads return zero with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= led_ind_pkg::RESP_OKAY;
      rdata_q  <= 32'h0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (rd_cfg | rd_stat) ? led_ind_pkg::RESP_OKAY : led_ind_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // ---- checks ----
  sequence ack_with_causes_s;
    latch_en && held_q && ack_raw && !causes_gone;
  endsequence

  sequence ack_clean_s;
    latch_en && held_q && ack_raw && !combined && causes_gone;
  endsequence

  combine_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (indication && act_col == led_ind_pkg::COL_RED && held_q == 1'b0)
      |-> (|(sig_in ^ inv_mask)) ##1 (led_red_q && !led_green_q))
    else $error("combined input did not light active red");

  active_colour_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (combined && act_col == led_ind_pkg::COL_GREEN) |=> (led_green_q && !led_red_q))
    else $error("active green not shown");

  inactive_colour_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!combined && !held_q && inact_col == led_ind_pkg::COL_RED) |=> (led_red_q && !led_green_q))
    else $error("inactive red not shown");

  off_dark_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (indication ? act_col == led_ind_pkg::COL_OFF : inact_col == led_ind_pkg::COL_OFF)
      |=> (!led_red_q && !led_green_q))
    else $error("off colour lit the led");

  latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (latch_en && combined && !wr_cfg) |=> held_q)
    else $error("pickup was not latched");

  ack_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ack_with_causes_s and (!wr_cfg)) |=> held_q)
    else $error("ack cleared while causes present");

  ack_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ack_clean_s and (!wr_cfg)) |=> !held_q)
    else $error("clean ack did not clear latch");

  no_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !latch_en |=> !held_q)
    else $error("held without latching");

  ack_expose_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (ack_state_q == $past(ack_raw)))
    else $error("ack state output mismatch");

  one_colour_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(led_red_q && led_green_q))
    else $error("red and green lit together");

  blink_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
    blink_tick |=> (phase_q != $past(phase_q)) && (blink_cnt_q == 32'h0))
    else $error("blink phase did not toggle on tick");

  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_q && !s_axi_bready) |=> (bvalid_q && $stable(bresp_q)))
    else $error("write response dropped early");

endmodule : led_indicator_logic

// *** verif/led_indicator_logic_bench.sv ***
// self-checking bench for the indicator logic
`timescale 1ns/100ps

module led_indicator_logic_bench;
  localparam int HALF = 8;
  logic        aclk = 1'b0, aresetn = 1'b0, ack_ext = 1'b0, clr = 1'b1;
  logic [4:0]  sig_in = 5'h00;
  logic        led_red, led_green, ack_state;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] d;
  logic [15:0] red_cnt, grn_cnt;
  int          fail_count = 0, n_compared = 0;
  // steady cases: config, inputs, expected red, expected green
  logic [38:0] rows [8] = '{
    {32'h0041_0000, 5'h00, 2'b00}, {32'h0041_0000, 5'h01, 2'b10},
    {32'h0010_0000, 5'h00, 2'b10}, {32'h0010_0000, 5'h10, 2'b01},
    {32'h0041_0004, 5'h00, 2'b10}, {32'h0041_0004, 5'h04, 2'b00},
    {32'h0001_0000, 5'h00, 2'b01}, {32'h0004_0000, 5'h08, 2'b00}};

  always #2.5 aclk = ~aclk;

  led_indicator_logic #(.NUM_SIG(5), .BLINK_HALF_CYC(HALF)) led_indicator_logic_inst (
    .aclk(aclk), .aresetn(aresetn), .sig_in(sig_in), .ack_ext(ack_ext),
    .led_red(led_red), .led_green(led_green), .ack_state(ack_state),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  led_panel_model led_panel_model_inst (
    .aclk(aclk), .clr(clr), .led_red(led_red), .led_green(led_green),
    .red_cnt(red_cnt), .grn_cnt(grn_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // write with both items offered together, each released once taken
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_on, w_on, b_on;
    int   n;
    @(posedge aclk);  // an edge between transfers, so bready is never set twice in one step
    aw_on = 1'b1; w_on = 1'b1; b_on = 1'b1; n = 0;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while ((aw_on || w_on || b_on) && n < 200) begin
      @(posedge aclk);
      n++;
      if (aw_on && awready) begin aw_on = 1'b0; awvalid <= 1'b0; end
      if (w_on && wready) begin w_on = 1'b0; wvalid <= 1'b0; end
      if (!aw_on && !w_on && b_on && bvalid) begin b_on = 1'b0; resp = bresp; bready <= 1'b0; end
    end
    if (n >= 200) fail_count++;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar_on, r_on;
    int   n;
    @(posedge aclk);  // an edge between transfers, so rready is never set twice in one step
    ar_on = 1'b1; r_on = 1'b1; n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while ((ar_on || r_on) && n < 200) begin
      @(posedge aclk);
      n++;
      if (ar_on && arready) begin ar_on = 1'b0; arvalid <= 1'b0; end
      else if (!ar_on && r_on && rvalid) begin r_on = 1'b0; v = rdata; resp = rresp; rready <= 1'b0; end
    end
    if (n >= 200) fail_count++;
  endtask : axi_read

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // hang guard: the whole sequence needs a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end

  initial begin
    tick(12);
    aresetn <= 1'b1;
    tick(1);
    check(32'({led_red, led_green, ack_state}), 32'h0);
    axi_read(led_ind_pkg::CFG_OFS, d, r);
    check(d, led_ind_pkg::CFG_RESET);
    axi_read(4'h8, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(led_ind_pkg::RESP_SLVERR));
    axi_write(4'hC, 32'hFFFF_FFFF, r);
    check(32'(r), 32'(led_ind_pkg::RESP_SLVERR));
    foreach (rows[i]) begin
      axi_write(led_ind_pkg::CFG_OFS, rows[i][38:7], r);
      sig_in <= rows[i][6:2];
      tick(4);
      check(32'({led_red, led_green}), 32'(rows[i][1:0]));
    end
    // latch with acknowledge taken from the external line
    axi_write(led_ind_pkg::CFG_OFS, 32'h0541_0100, r);
    sig_in <= 5'h02;
    tick(3);
    sig_in <= 5'h00;
    tick(4);
    check(32'({led_red, led_green}), 32'h2);
    // an ack that overlaps its cause and leaves with it must not clear the hold
    sig_in  <= 5'h02;
    ack_ext <= 1'b1;
    tick(3);
    sig_in  <= 5'h00;
    ack_ext <= 1'b0;
    tick(4);
    check(32'(led_red), 32'h1);
    ack_ext <= 1'b1;
    tick(2);
    check(32'(ack_state), 32'h1);
    axi_read(led_ind_pkg::STATUS_OFS, d, r);
    check(32'(d[10]), 32'h1);
    tick(3);
    check(32'({led_red, led_green}), 32'h0);
    ack_ext <= 1'b0;
    sig_in <= 5'h01;
    tick(3);
    sig_in <= 5'h00;
    tick(3);
    check(32'(led_red), 32'h1);
    // dropping the latch frees the hold; ack now follows input 3 and is ignored
    axi_write(led_ind_pkg::CFG_OFS, 32'h0341_0000, r);
    tick(3);
    check(32'({led_red, led_green}), 32'h0);
    sig_in <= 5'h08;
    tick(3);
    check(32'({led_red, ack_state}), 32'h3);
    sig_in <= 5'h00;
    tick(3);
    check(32'({led_red, led_green}), 32'h0);
    // flashing colours: four whole periods give half of the time lit
    for (int c = 2; c <= 3; c++) begin
      axi_write(led_ind_pkg::CFG_OFS, {12'h004, 1'b0, 3'(c), 16'h0000}, r);
      sig_in <= 5'h01;
      tick(4);
      clr <= 1'b0;
      tick(8 * HALF);
      #1;  // counters settled after the last counted edge
      check({red_cnt, grn_cnt}, (c == 2) ? {16'(4 * HALF), 16'h0} : {16'h0, 16'(4 * HALF)});
      clr <= 1'b1;
    end
    // reset in mid-run drops the leds and restores the configuration
    tick(1);
    aresetn <= 1'b0;
    sig_in  <= 5'h00;
    tick(3);
    aresetn <= 1'b1;
    tick(2);
    check(32'({led_red, led_green, ack_state}), 32'h0);
    axi_read(led_ind_pkg::CFG_OFS, d, r);
    check(d, led_ind_pkg::CFG_RESET);
    give_verdict();
  end
endmodule : led_indicator_logic_bench

// *** verif/led_panel_model.sv ***
// front-panel led model: counts the cycles each colour is lit
`timescale 1ns/100ps

module led_panel_model (
  input  wire logic        aclk,
  input  wire logic        clr,
  input  wire logic        led_red,
  input  wire logic        led_green,
  output logic [15:0]      red_cnt,
  output logic [15:0]      grn_cnt
);
  // lit time per colour, so blink duty can be judged over whole periods
  always_ff @(posedge aclk) begin
    if (clr) begin
      red_cnt <= 16'h0000;
      grn_cnt <= 16'h0000;
    end else begin
      red_cnt <= red_cnt + {15'h0000, led_red};
      grn_cnt <= grn_cnt + {15'h0000, led_green};
    end
  end
endmodule : led_panel_model
